// ### verilog/oag_params.svh
/*
 * Constants for the operand address generator: register indices, step
 * sizes, status bit positions, mode field encodings and reset values.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

`define OAG_PC_IDX 4'h0
`define OAG_SW_IDX 4'h2
`define OAG_NUM_REGS 16
`define OAG_RESET_PC 16'h0000
`define OAG_WORD_STEP 16'h0002
`define OAG_BYTE_STEP 16'h0001
`define OAG_FLAG_Z 1
`define OAG_FLAG_N 2
`define OAG_MODE_REG 2'h0
`define OAG_MODE_IDX 2'h1
`define OAG_MODE_PTR 2'h2
`define OAG_MODE_PINC 2'h3
`define OAG_ZERO_WORD 16'h0000
`define OAG_ZERO_BYTE 8'h00

`endif

// ### verilog/oag_pkg.sv
/*
 * Types shared by the operand address generator files.
 * Assumes a 16-bit core bus with word-wide read data.
 */
package oag_pkg;

  // two-operand instruction word layout
  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] src;
    logic dst_mode;
    logic byte_op;
    logic [1:0] source_mode_field;
    logic [3:0] dst;
  } insn_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic byte_op;
  } mem_req_type;

  typedef enum logic [2:0] {
    S_FETCH,
    S_SRC,
    S_SEXT,
    S_SREAD,
    S_DST,
    S_DEXT,
    S_WRITE
  } state_type;

endpackage

// ### verilog/oag_ea_unit.sv
/*
 * Effective address former for base_plus_offset_mode and its symbolic
 * and absolute variants. Purely combinational; the caller registers it.
 */
`timescale 1ns/1ps
`include "oag_params.svh"

module oag_ea_unit (
  input wire logic [3:0] i_base_idx, // register chosen as base
  input wire logic [15:0] i_base_val, // that register's value
  input wire logic [15:0] i_ext_word, // extension word just read
  input wire logic [15:0] i_ext_addr, // address the extension came from
  output logic [15:0] o_addr // operand address
);

  always_comb begin
    case (i_base_idx)
      `OAG_PC_IDX: o_addr = i_ext_addr + i_ext_word;
      `OAG_SW_IDX: o_addr = `OAG_ZERO_WORD + i_ext_word;
      default: o_addr = i_base_val + i_ext_word;
    endcase
  end

endmodule // oag_ea_unit

// ### verilog/oag_core.sv
/*
 * Operand address generator: register file, instruction fetch, source
 * and destination operand addressing, byte handling and N/Z flags for a
 * move-style two-operand instruction.
 * Assumes a memory that answers each held request with one i_mem_ready
 * cycle on the same clock, returning a full 16-bit word at even address.
 */
`timescale 1ns/1ps
`include "oag_params.svh"

module oag_core #(
  parameter logic [15:0] RESET_PC = `OAG_RESET_PC
) (
  input wire logic i_mclk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [15:0] i_mem_rdata, // read data from memory
  input wire logic i_mem_ready, // memory finished the held request
  input wire logic [3:0] i_dbg_sel, // register to show on o_dbg_data
  output oag_pkg::mem_req_type o_mem_req, // held memory request
  output logic [15:0] o_pc, // program counter
  output logic [15:0] o_status, // status word register
  output logic [15:0] o_dbg_data, // selected register, one cycle late
  output logic o_insn_done // pulse when an instruction retires
);

  oag_pkg::state_type state_reg;
  oag_pkg::insn_type ir_reg;
  oag_pkg::mem_req_type req_reg;
  logic [15:0] regs_reg [`OAG_NUM_REGS];
  logic [15:0] opnd_reg;
  logic [15:0] addr_reg;
  logic [15:0] dbg_reg;
  logic done_reg;
  logic [3:0] base_idx;
  logic [15:0] ea_addr;
  logic [15:0] step;
  logic [15:0] pc;
  logic mem_done;
  logic mem_idle;

  function automatic logic [15:0] step_of(input logic byte_op);
    step_of = byte_op ? `OAG_BYTE_STEP : `OAG_WORD_STEP;
  endfunction

  // byte result keeps only the low lane, upper half forced to zero
  function automatic logic [15:0] byte_fit(input logic byte_op, input logic [15:0] v);
    byte_fit = byte_op ? {`OAG_ZERO_BYTE, v[7:0]} : v;
  endfunction

  assign pc = regs_reg[`OAG_PC_IDX];
  assign step = step_of(ir_reg.byte_op);
  assign mem_done = (req_reg.rd | req_reg.wr) & i_mem_ready;
  assign mem_idle = ~(req_reg.rd | req_reg.wr);
  assign base_idx = (state_reg == oag_pkg::S_DEXT) ? ir_reg.dst : ir_reg.src;

  oag_ea_unit u_ea (
    .i_base_idx(base_idx),
    .i_base_val(regs_reg[base_idx]),
    .i_ext_word(i_mem_rdata),
    .i_ext_addr(pc),
    .o_addr(ea_addr)
  );

  // sequencer, register file and memory request share one process so
  // that counter steps and register writes never collide
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= oag_pkg::S_FETCH;
      ir_reg <= '0;
      req_reg <= '0;
      opnd_reg <= `OAG_ZERO_WORD;
      addr_reg <= `OAG_ZERO_WORD;
      done_reg <= 1'b0;
      for (int i = 0; i < `OAG_NUM_REGS; i++) begin
        regs_reg[i] <= `OAG_ZERO_WORD;
      end
      regs_reg[`OAG_PC_IDX] <= RESET_PC;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        oag_pkg::S_FETCH: begin
          if (mem_idle) begin
            req_reg <= '{addr: pc, wdata: `OAG_ZERO_WORD, rd: 1'b1, wr: 1'b0, byte_op: 1'b0};
          end else if (mem_done) begin
            req_reg.rd <= 1'b0;
            ir_reg <= oag_pkg::insn_type'(i_mem_rdata);
            regs_reg[`OAG_PC_IDX] <= pc + `OAG_WORD_STEP;
            state_reg <= oag_pkg::S_SRC;
          end
        end
        oag_pkg::S_SRC: begin
          case (ir_reg.source_mode_field)
            `OAG_MODE_REG: begin
              opnd_reg <= byte_fit(ir_reg.byte_op, regs_reg[ir_reg.src]);
              state_reg <= oag_pkg::S_DST;
            end
            `OAG_MODE_IDX: state_reg <= oag_pkg::S_SEXT;
            `OAG_MODE_PTR: begin
              addr_reg <= regs_reg[ir_reg.src];
              state_reg <= oag_pkg::S_SREAD;
            end
            default: begin
              addr_reg <= regs_reg[ir_reg.src];
              if (ir_reg.src == `OAG_PC_IDX) begin
                regs_reg[`OAG_PC_IDX] <= pc + `OAG_WORD_STEP;
              end else begin
                regs_reg[ir_reg.src] <= regs_reg[ir_reg.src] + step;
              end
              state_reg <= oag_pkg::S_SREAD;
            end
          endcase
        end
        oag_pkg::S_SEXT: begin
          if (mem_idle) begin
            req_reg <= '{addr: pc, wdata: `OAG_ZERO_WORD, rd: 1'b1, wr: 1'b0, byte_op: 1'b0};
          end else if (mem_done) begin
            req_reg.rd <= 1'b0;
            addr_reg <= ea_addr;
            regs_reg[`OAG_PC_IDX] <= pc + `OAG_WORD_STEP;
            state_reg <= oag_pkg::S_SREAD;
          end
        end
        oag_pkg::S_SREAD: begin
          if (mem_idle) begin
            req_reg <= '{addr: addr_reg, wdata: `OAG_ZERO_WORD, rd: 1'b1, wr: 1'b0,
                         byte_op: ir_reg.byte_op};
          end else if (mem_done) begin
            req_reg.rd <= 1'b0;
            // odd byte address picks the high lane of the returned word
            if (ir_reg.byte_op && addr_reg[0]) begin
              opnd_reg <= {`OAG_ZERO_BYTE, i_mem_rdata[15:8]};
            end else begin
              opnd_reg <= byte_fit(ir_reg.byte_op, i_mem_rdata);
            end
            state_reg <= oag_pkg::S_DST;
          end
        end
        oag_pkg::S_DST: begin
          if (!ir_reg.dst_mode) begin
            regs_reg[ir_reg.dst] <= byte_fit(ir_reg.byte_op, opnd_reg);
            done_reg <= 1'b1;
            state_reg <= oag_pkg::S_FETCH;
          end else begin
            state_reg <= oag_pkg::S_DEXT;
          end
        end
        oag_pkg::S_DEXT: begin
          if (mem_idle) begin
            req_reg <= '{addr: pc, wdata: `OAG_ZERO_WORD, rd: 1'b1, wr: 1'b0, byte_op: 1'b0};
          end else if (mem_done) begin
            req_reg.rd <= 1'b0;
            addr_reg <= ea_addr;
            regs_reg[`OAG_PC_IDX] <= pc + `OAG_WORD_STEP;
            state_reg <= oag_pkg::S_WRITE;
          end
        end
        oag_pkg::S_WRITE: begin
          if (mem_idle) begin
            req_reg <= '{addr: addr_reg, wdata: ir_reg.byte_op ?
                         {opnd_reg[7:0], opnd_reg[7:0]} : opnd_reg,
                         rd: 1'b0, wr: 1'b1, byte_op: ir_reg.byte_op};
          end else if (mem_done) begin
            req_reg.wr <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= oag_pkg::S_FETCH;
          end
        end
        default: state_reg <= oag_pkg::S_FETCH;
      endcase
      // flags follow the retired result; an explicit write to the status
      // word register in register mode takes precedence
      if (done_reg && !(ir_reg.dst == `OAG_SW_IDX && !ir_reg.dst_mode)) begin
        if (ir_reg.byte_op) begin
          regs_reg[`OAG_SW_IDX][`OAG_FLAG_N] <= opnd_reg[7];
          regs_reg[`OAG_SW_IDX][`OAG_FLAG_Z] <= (opnd_reg[7:0] == `OAG_ZERO_BYTE);
        end else begin
          regs_reg[`OAG_SW_IDX][`OAG_FLAG_N] <= opnd_reg[15];
          regs_reg[`OAG_SW_IDX][`OAG_FLAG_Z] <= (opnd_reg == `OAG_ZERO_WORD);
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dbg_reg <= `OAG_ZERO_WORD;
    end else begin
      dbg_reg <= regs_reg[i_dbg_sel];
    end
  end

  // outputs taken straight from flops
  assign o_mem_req = req_reg;
  assign o_pc = regs_reg[`OAG_PC_IDX];
  assign o_status = regs_reg[`OAG_SW_IDX];
  assign o_dbg_data = dbg_reg;
  assign o_insn_done = done_reg;

  a_reg_mode_direct: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SRC && ir_reg.source_mode_field == `OAG_MODE_REG)
    |=> (state_reg == oag_pkg::S_DST && opnd_reg == byte_fit(ir_reg.byte_op,
         $past(regs_reg[ir_reg.src]))))
    else $error("register mode operand wrong");

  a_indexed_addr_sum: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SEXT && mem_done && ir_reg.src != `OAG_PC_IDX
     && ir_reg.src != `OAG_SW_IDX)
    |=> addr_reg == $past(regs_reg[ir_reg.src]) + $past(i_mem_rdata))
    else $error("indexed address not base plus offset");

  a_symbolic_addr_sum: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_DEXT && mem_done && ir_reg.dst == `OAG_PC_IDX)
    |=> addr_reg == $past(pc) + $past(i_mem_rdata) && pc == $past(pc) + `OAG_WORD_STEP)
    else $error("symbolic address not extension address plus offset");

  a_absolute_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SEXT && mem_done && ir_reg.src == `OAG_SW_IDX)
    |=> addr_reg == $past(i_mem_rdata))
    else $error("absolute address not the extension word");

  a_pointer_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SRC && ir_reg.source_mode_field == `OAG_MODE_PTR)
    |=> state_reg == oag_pkg::S_SREAD ##1 (o_mem_req.rd && o_mem_req.addr == addr_reg))
    else $error("pointer mode read at wrong address");

  a_postinc_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SRC && ir_reg.source_mode_field == `OAG_MODE_PINC
     && ir_reg.src != `OAG_PC_IDX)
    |=> regs_reg[ir_reg.src] == $past(regs_reg[ir_reg.src]) + step_of(ir_reg.byte_op)
        && addr_reg == $past(regs_reg[ir_reg.src]))
    else $error("postincrement step wrong");

  a_immediate_fetch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SRC && ir_reg.source_mode_field == `OAG_MODE_PINC
     && ir_reg.src == `OAG_PC_IDX)
    |=> addr_reg == $past(pc) && pc == $past(pc) + `OAG_WORD_STEP)
    else $error("immediate word not taken at counter");

  a_byte_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_DST && !ir_reg.dst_mode && ir_reg.byte_op
     && ir_reg.dst != `OAG_PC_IDX && ir_reg.dst != `OAG_SW_IDX)
    |=> regs_reg[ir_reg.dst][15:8] == `OAG_ZERO_BYTE)
    else $error("byte register write kept upper byte");

  a_byte_flags: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (done_reg && ir_reg.byte_op && ir_reg.dst_mode)
    |=> o_status[`OAG_FLAG_Z] == ($past(opnd_reg[7:0]) == `OAG_ZERO_BYTE)
        && o_status[`OAG_FLAG_N] == $past(opnd_reg[7]))
    else $error("byte flags not from low byte");

  a_fetch_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_FETCH && mem_done)
    |=> pc == $past(pc) + `OAG_WORD_STEP && state_reg == oag_pkg::S_SRC)
    else $error("fetch did not step counter by two");

  a_base_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SEXT && mem_done && ir_reg.src != `OAG_PC_IDX)
    |=> $stable(regs_reg[ir_reg.src]))
    else $error("indexed base register modified");

  a_ext_pc_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ((state_reg == oag_pkg::S_SEXT || state_reg == oag_pkg::S_DEXT) && mem_done)
    |=> pc == $past(pc) + `OAG_WORD_STEP)
    else $error("extension word did not step counter");

  a_symbolic_src_sum: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SEXT && mem_done && ir_reg.src == `OAG_PC_IDX)
    |=> addr_reg == $past(pc) + $past(i_mem_rdata))
    else $error("symbolic source address not counter plus offset");

  a_absolute_dst: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_DEXT && mem_done && ir_reg.dst == `OAG_SW_IDX)
    |=> addr_reg == $past(i_mem_rdata))
    else $error("absolute destination not the extension word");

  // ir_reg cannot change before the next fetch completes, so no $past needed
  a_src_mode_decode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_SRC)
    |=> (state_reg == oag_pkg::S_DST) == (ir_reg.source_mode_field == `OAG_MODE_REG)
        && (state_reg == oag_pkg::S_SEXT) == (ir_reg.source_mode_field == `OAG_MODE_IDX))
    else $error("source mode decoded to wrong step");

  a_dst_mode_decode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_DST)
    |=> (state_reg == oag_pkg::S_DEXT) == ir_reg.dst_mode
        && o_insn_done == !ir_reg.dst_mode)
    else $error("destination mode decoded to wrong step");

  // flags land one edge later, so a status source is still stable here
  a_reg_move_copy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg == oag_pkg::S_DST && !ir_reg.dst_mode && ir_reg.dst != ir_reg.src)
    |=> regs_reg[ir_reg.dst] == byte_fit(ir_reg.byte_op, $past(opnd_reg))
        && $stable(regs_reg[ir_reg.src]))
    else $error("register move did not copy or disturbed source");

endmodule // oag_core

// ### test/oag_mem_model.sv
/*
 * Behavioural program and data memory for the operand address generator.
 * Assumes the core holds each request until o_ready and drops it after.
 */
`timescale 1ns/1ps

module oag_mem_model (
  input wire logic i_mclk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire oag_pkg::mem_req_type i_req, // held request from the core
  input wire logic i_stall, // withhold answers while high
  input wire logic [3:0] i_wait, // extra cycles before answering
  output logic [15:0] o_rdata, // read word
  output logic o_ready // one-cycle completion
);
  logic [15:0] mem [0:32767];
  logic [3:0] cnt_reg;
  logic busy;

  assign busy = (i_req.rd || i_req.wr) && !i_stall && !o_ready;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      cnt_reg <= 4'h0;
      o_rdata <= 16'h0000;
    end else if (busy && cnt_reg >= i_wait) begin
      o_ready <= 1'b1;
      cnt_reg <= 4'h0;
      if (i_req.rd) begin
        o_rdata <= mem[i_req.addr[15:1]];
      end else if (!i_req.byte_op) begin
        mem[i_req.addr[15:1]] <= i_req.wdata;
      end else if (i_req.addr[0]) begin
        mem[i_req.addr[15:1]][15:8] <= i_req.wdata[15:8];
      end else begin
        mem[i_req.addr[15:1]][7:0] <= i_req.wdata[7:0];
      end
    end else begin
      o_ready <= 1'b0;
      // bus not driven: never leave the last word standing
      o_rdata <= ~o_rdata;
      if (busy) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule // oag_mem_model

// ### test/tb_operand_address_generator.sv
/*
 * Self-checking bench for the operand address generator core.
 * Assumes oag_mem_model as memory; code is placed at the fetch pointer.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end

module tb_operand_address_generator;
  logic mclk, rst_n, stall, ready, done;
  logic [3:0] wait_c, sel;
  logic [15:0] rdata, pc, status, dbg, lp, v;
  oag_pkg::mem_req_type req;
  int num_errors = 0;
  int total_checks = 0;

  oag_core #(.RESET_PC(16'h0100)) u_oag_core (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_mem_rdata(rdata), .i_mem_ready(ready), .i_dbg_sel(sel), .o_mem_req(req),
    .o_pc(pc), .o_status(status), .o_dbg_data(dbg), .o_insn_done(done));
  oag_mem_model u_mem (.i_mclk(mclk), .i_rst_n(rst_n), .i_req(req), .i_stall(stall),
    .i_wait(wait_c), .o_rdata(rdata), .o_ready(ready));

  function automatic logic [15:0] ins(input logic [3:0] s, input logic ad, input logic b,
                                      input logic [1:0] as, input logic [3:0] d);
    return {4'h4, s, ad, b, as, d};
  endfunction

  task put(input logic [15:0] w);
    u_mem.mem[lp[15:1]] = w;
    lp = lp + 16'h0002;
  endtask

  task poke(input logic [15:0] a, input logic [15:0] w);
    u_mem.mem[a[15:1]] = w;
  endtask

  // immediate load of a register
  task setr(input logic [3:0] r, input logic [15:0] w);
    put(ins(4'h0, 1'b0, 1'b0, 2'h3, r));
    put(w);
  endtask

  // release the memory until n instructions retire, then freeze the next fetch
  task run(input int n);
    int k;
    int c;
    c = 0;
    @(negedge mclk);
    stall = 1'b0;
    for (k = 0; k < 400 && c < n; k++) begin
      @(negedge mclk);
      if (done === 1'b1) c++;
    end
    stall = 1'b1;
    `CHK("retired", n, c)
    `CHK("pc", lp, pc)
  endtask

  task reg_is(input logic [3:0] r, input logic [15:0] e);
    @(negedge mclk);
    sel = r;
    @(negedge mclk);
    `CHK($sformatf("reg %0d", r), e, dbg)
  endtask

  task t_immediate;
    setr(4'hA, 16'hA023);
    setr(4'hB, 16'hFA15);
    setr(4'h4, 16'h0044);
    setr(4'hF, 16'h00FF);
    run(4);
    reg_is(4'hA, 16'hA023);
    reg_is(4'hB, 16'hFA15);
    reg_is(4'h4, 16'h0044);
    reg_is(4'hF, 16'h00FF);
    $display("test immediate done");
  endtask

  task t_register;
    put(ins(4'hA, 1'b0, 1'b0, 2'h0, 4'hB));
    run(1);
    reg_is(4'hB, 16'hA023);
    reg_is(4'hA, 16'hA023);
    `CHK("flag n", 1'b1, status[2])
    `CHK("flag z", 1'b0, status[1])
    $display("test register done");
  endtask

  task t_indexed;
    wait_c = 4'h3;
    setr(4'h5, 16'h1080);
    setr(4'h6, 16'h108C);
    poke(16'h1082, 16'h1234);
    poke(16'h1092, 16'h5555);
    put(ins(4'h5, 1'b1, 1'b0, 2'h1, 4'h6));
    put(16'h0002);
    put(16'h0006);
    run(3);
    `CHK("indexed dst", 16'h1234, u_mem.mem[16'h1092 >> 1])
    reg_is(4'h5, 16'h1080);
    reg_is(4'h6, 16'h108C);
    wait_c = 4'h0;
    $display("test indexed done");
  endtask

  task t_symbolic;
    poke(16'hF016, 16'hA123);
    v = lp + 16'h0002;
    put(ins(4'h0, 1'b1, 1'b0, 2'h1, 4'h2));
    put(16'hF016 - v);
    put(16'h1114);
    run(1);
    `CHK("symbolic src", 16'hA123, u_mem.mem[16'h1114 >> 1])
    v = lp + 16'h0004;
    put(ins(4'h2, 1'b1, 1'b0, 2'h1, 4'h0));
    put(16'hF016);
    put(16'h1200 - v);
    run(1);
    `CHK("absolute src", 16'hA123, u_mem.mem[16'h1200 >> 1])
    $display("test symbolic done");
  endtask

  task t_pointer;
    setr(4'h7, 16'h2001);
    poke(16'h2000, 16'h8355);
    poke(16'h2002, 16'h0000);
    poke(16'h108C, 16'h0000);
    put(ins(4'h7, 1'b0, 1'b1, 2'h3, 4'h8));
    run(2);
    reg_is(4'h8, 16'h0083);
    reg_is(4'h7, 16'h2002);
    `CHK("byte flag n", 1'b1, status[2])
    put(ins(4'h7, 1'b0, 1'b0, 2'h2, 4'h9));
    run(1);
    reg_is(4'h9, 16'h0000);
    reg_is(4'h7, 16'h2002);
    `CHK("flag z", 1'b1, status[1])
    put(ins(4'h7, 1'b0, 1'b0, 2'h3, 4'hD));
    run(1);
    reg_is(4'h7, 16'h2004);
    poke(16'h2004, 16'h12F0);
    put(ins(4'h7, 1'b0, 1'b1, 2'h2, 4'hE));
    run(1);
    reg_is(4'hE, 16'h00F0);
    `CHK("byte even flag z", 1'b0, status[1])
    `CHK("byte even flag n", 1'b1, status[2])
    put(ins(4'hA, 1'b0, 1'b1, 2'h0, 4'hC));
    put(ins(4'hA, 1'b1, 1'b1, 2'h0, 4'h6));
    put(16'h0001);
    run(2);
    reg_is(4'hC, 16'h0023);
    `CHK("byte to odd", 16'h2300, u_mem.mem[16'h108C >> 1])
    $display("test pointer done");
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    num_errors++;
    $display("FAIL watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    stall = 1'b1;
    wait_c = 4'h0;
    sel = 4'h0;
    lp = 16'h0100;
    repeat (8) @(negedge mclk);
    `CHK("reset pc", 16'h0100, pc)
    rst_n = 1'b1;
    t_immediate();
    t_register();
    t_indexed();
    t_symbolic();
    t_pointer();
    summarize();
  end
endmodule // tb_operand_address_generator
